// ==== escs_bus_cycle.v ====
`timescale 1ns/1ps
`default_nettype none
`include "escs_consts.vh"
// one strobed write cycle on the memory bus
module escs_bus_cycle (
  // clock and reset
  input wire core_clk,
  input wire nrst,
  // request
  input wire start,
  input wire [`ESCS_AW-1:0] addr_in,
  input wire [`ESCS_DW-1:0] data_in,
  output reg done,
  // memory pins
  output reg [`ESCS_AW-1:0] mem_addr,
  output reg [`ESCS_DW-1:0] mem_dq_o,
  output reg mem_dq_oe,
  output reg mem_ce_n,
  output reg mem_we_n,
  output reg mem_oe_n
);
  localparam S_IDLE = 2'h0;
  localparam S_SETUP = 2'h1;
  localparam S_PULSE = 2'h2;
  localparam S_HOLD = 2'h3;
  reg [1:0] st_r;
  reg [`ESCS_CNT_W-1:0] cnt_r;
  always @(posedge core_clk) begin
    done <= 1'b0;
    if (!nrst) begin
      st_r <= S_IDLE;
      cnt_r <= {`ESCS_CNT_W{1'b0}};
      mem_addr <= {`ESCS_AW{1'b0}};
      mem_dq_o <= {`ESCS_DW{1'b0}};
      mem_dq_oe <= 1'b0;
      mem_ce_n <= 1'b1;
      mem_we_n <= 1'b1;
      mem_oe_n <= 1'b1;
    end else begin
      case (st_r)
        S_IDLE: begin
          if (start) begin
            mem_addr <= addr_in;
            mem_dq_o <= data_in;
            mem_dq_oe <= 1'b1;
            mem_ce_n <= 1'b0;
            cnt_r <= `ESCS_SETUP_CYC;
            st_r <= S_SETUP;
          end
        end
        S_SETUP: begin
          if (cnt_r == {`ESCS_CNT_W{1'b0}}) begin
            mem_we_n <= 1'b0;
            cnt_r <= `ESCS_PULSE_CYC;
            st_r <= S_PULSE;
          end else begin
            cnt_r <= cnt_r - 1'b1;
          end
        end
        S_PULSE: begin
          if (cnt_r == {`ESCS_CNT_W{1'b0}}) begin
            mem_we_n <= 1'b1;
            cnt_r <= `ESCS_HOLD_CYC;
            st_r <= S_HOLD;
          end else begin
            cnt_r <= cnt_r - 1'b1;
          end
        end
        S_HOLD: begin
          if (cnt_r == {`ESCS_CNT_W{1'b0}}) begin
            mem_ce_n <= 1'b1;
            mem_dq_oe <= 1'b0;
            done <= 1'b1;
            st_r <= S_IDLE;
          end else begin
            cnt_r <= cnt_r - 1'b1;
          end
        end
        default: st_r <= S_IDLE;
      endcase
    end
  end
endmodule
`default_nettype wire

// ==== escs_consts.vh ====
`ifndef ESCS_CONSTS_VH
`define ESCS_CONSTS_VH
// command addresses and data
`define ESCS_ADDR_A 13'h1555
`define ESCS_ADDR_B 13'h0AAA
`define ESCS_DAT_UNLOCK1 8'hAA
`define ESCS_DAT_UNLOCK2 8'h55
`define ESCS_DAT_PROT_ON 8'hA0
`define ESCS_DAT_EXTEND 8'h80
`define ESCS_DAT_PROT_OFF 8'h20
`define ESCS_DAT_CLEAR 8'h10
`define ESCS_DAT_AC_OFF 8'h40
`define ESCS_DAT_AC_ON 8'h50
// operation codes
`define ESCS_OP_WRITE 3'h0
`define ESCS_OP_PROT_ON 3'h1
`define ESCS_OP_PROT_OFF 3'h2
`define ESCS_OP_CLEAR 3'h3
`define ESCS_OP_AC_OFF 3'h4
`define ESCS_OP_AC_ON 3'h5
// strobe timing in ns, and the core_clk period (5 ns)
`define ESCS_T_SETUP_NS 50
`define ESCS_T_PULSE_NS 150
`define ESCS_T_HOLD_NS 100
`define ESCS_CLK_NS 5
// counts below are the ns figures rounded up, sized to the counter width
`define ESCS_SETUP_CYC 8'h0A
`define ESCS_PULSE_CYC 8'h1E
`define ESCS_HOLD_CYC 8'h14
// byte load gap must stay below 200 us; we use 1 us spacing
`define ESCS_T_BLC_MAX_US 200
`define ESCS_T_GAP_NS 1000
`define ESCS_GAP_CYC 8'hC8
`define ESCS_CNT_W 8
`define ESCS_AW 13
`define ESCS_DW 8
`define ESCS_PAGE_MAX 7'h40
`endif

// ==== escs_host_seq.v ====
`timescale 1ns/1ps
`default_nettype none
`include "escs_consts.vh"
module escs_host_seq (
  // clock and reset
  input wire core_clk,
  input wire nrst,
  // user command
  input wire cmd_valid,
  input wire [2:0] cmd_op,
  input wire cmd_prot_on,
  input wire cmd_cleared,
  output reg cmd_ready,
  // page data stream
  input wire pg_valid,
  input wire [`ESCS_AW-1:0] pg_addr,
  input wire [`ESCS_DW-1:0] pg_data,
  input wire pg_last,
  output reg pg_ready,
  // status
  output reg prot_state,
  output reg ac_off_state,
  output reg cleared_state,
  output reg cmd_err,
  // memory pins
  output wire [`ESCS_AW-1:0] mem_addr,
  output wire [`ESCS_DW-1:0] mem_dq_o,
  output wire mem_dq_oe,
  output wire mem_ce_n,
  output wire mem_we_n,
  output wire mem_oe_n
);
  // ==========================================
  // state machine
  localparam S_IDLE = 3'h0;
  localparam S_PFX = 3'h1;
  localparam S_PAGE = 3'h2;
  localparam S_GAP = 3'h3;
  localparam S_WAIT = 3'h4;
  reg [2:0] st_r;
  reg [2:0] op_r;
  reg [2:0] step_r;
  reg [2:0] nsteps_r;
  reg with_data_r;
  reg cyc_done_r;
  reg start_r;
  reg [`ESCS_AW-1:0] a_r;
  reg [`ESCS_DW-1:0] d_r;
  reg [6:0] cnt_pg_r;
  reg last_r;
  reg [`ESCS_CNT_W-1:0] gap_r;
  wire done;
  reg [`ESCS_AW-1:0] step_a;
  reg [`ESCS_DW-1:0] step_d;
  // ==========================================
  // prefix table
  always @* begin
    step_a = `ESCS_ADDR_A;
    step_d = `ESCS_DAT_UNLOCK1;
    case (step_r)
      3'h0: step_d = `ESCS_DAT_UNLOCK1;
      3'h1: begin
        step_a = `ESCS_ADDR_B;
        step_d = `ESCS_DAT_UNLOCK2;
      end
      3'h2: step_d = (nsteps_r == 3'h3) ? `ESCS_DAT_PROT_ON : `ESCS_DAT_EXTEND;
      3'h3: step_d = `ESCS_DAT_UNLOCK1;
      3'h4: begin
        step_a = `ESCS_ADDR_B;
        step_d = `ESCS_DAT_UNLOCK2;
      end
      3'h5: begin
        case (op_r)
          `ESCS_OP_PROT_OFF: step_d = `ESCS_DAT_PROT_OFF;
          `ESCS_OP_CLEAR: step_d = `ESCS_DAT_CLEAR;
          `ESCS_OP_AC_OFF: step_d = `ESCS_DAT_AC_OFF;
          default: step_d = `ESCS_DAT_AC_ON;
        endcase
      end
      default: step_d = `ESCS_DAT_UNLOCK1;
    endcase
  end
  escs_bus_cycle u_cyc (
    .core_clk(core_clk),
    .nrst(nrst),
    .start(start_r),
    .addr_in(a_r),
    .data_in(d_r),
    .done(done),
    .mem_addr(mem_addr),
    .mem_dq_o(mem_dq_o),
    .mem_dq_oe(mem_dq_oe),
    .mem_ce_n(mem_ce_n),
    .mem_we_n(mem_we_n),
    .mem_oe_n(mem_oe_n)
  );
  // ==========================================
  // sequencer
  always @(posedge core_clk) begin
    start_r <= 1'b0;
    cmd_err <= 1'b0;
    if (!nrst) begin
      st_r <= S_IDLE;
      op_r <= `ESCS_OP_WRITE;
      step_r <= 3'h0;
      nsteps_r <= 3'h0;
      with_data_r <= 1'b0;
      a_r <= {`ESCS_AW{1'b0}};
      d_r <= {`ESCS_DW{1'b0}};
      cnt_pg_r <= 7'h0;
      last_r <= 1'b0;
      gap_r <= {`ESCS_CNT_W{1'b0}};
      cyc_done_r <= 1'b0;
      cmd_ready <= 1'b0;
      pg_ready <= 1'b0;
      prot_state <= 1'b0;
      ac_off_state <= 1'b0;
      cleared_state <= 1'b0;
    end else begin
      cmd_ready <= 1'b0;
      pg_ready <= 1'b0;
      // the bus cycle ends before the gap runs out, so hold its done pulse
      if (done) begin
        cyc_done_r <= 1'b1;
      end
      case (st_r)
        S_IDLE: begin
          // alternate so that a request held high is always taken
          cmd_ready <= ~cmd_ready;
          step_r <= 3'h0;
          cnt_pg_r <= 7'h0;
          if (cmd_valid && cmd_ready) begin
            op_r <= cmd_op;
            with_data_r <= 1'b1;
            if (cmd_prot_on) begin
              prot_state <= 1'b1;
            end
            case (cmd_op)
              `ESCS_OP_PROT_ON: nsteps_r <= 3'h3;
              `ESCS_OP_WRITE: nsteps_r <= (prot_state || cmd_prot_on) ? 3'h3 : 3'h0;
              `ESCS_OP_CLEAR: begin
                nsteps_r <= 3'h6;
                with_data_r <= 1'b0;
              end
              `ESCS_OP_AC_OFF: begin
                nsteps_r <= 3'h6;
                if (!cleared_state && !cmd_cleared) begin
                  cmd_err <= 1'b1;
                end
              end
              default: nsteps_r <= 3'h6;
            endcase
            st_r <= S_PFX;
          end
        end
        S_PFX: begin
          if (step_r == nsteps_r) begin
            st_r <= with_data_r ? S_PAGE : S_WAIT;
          end else begin
            a_r <= step_a;
            d_r <= step_d;
            start_r <= 1'b1;
            cyc_done_r <= 1'b0;
            step_r <= step_r + 3'h1;
            gap_r <= `ESCS_GAP_CYC;
            st_r <= S_GAP;
          end
        end
        S_GAP: begin
          if (gap_r != {`ESCS_CNT_W{1'b0}}) begin
            gap_r <= gap_r - 1'b1;
          end else if (done || cyc_done_r) begin
            st_r <= (step_r == nsteps_r && !with_data_r) ? S_WAIT
                  : (step_r != nsteps_r) ? S_PFX : (last_r ? S_WAIT : S_PAGE);
          end
        end
        S_PAGE: begin
          // at least one page byte follows, else the device ignores it
          pg_ready <= ~pg_ready;
          if (pg_valid && pg_ready) begin
            a_r <= pg_addr;
            d_r <= pg_data;
            start_r <= 1'b1;
            cyc_done_r <= 1'b0;
            cnt_pg_r <= cnt_pg_r + 7'h1;
            last_r <= pg_last || (cnt_pg_r + 7'h1 == `ESCS_PAGE_MAX);
            gap_r <= `ESCS_GAP_CYC;
            st_r <= S_GAP;
          end
        end
        S_WAIT: begin
          last_r <= 1'b0;
          // erase and programming are timed by the device; host only tracks mode
          case (op_r)
            `ESCS_OP_PROT_ON: prot_state <= 1'b1;
            `ESCS_OP_PROT_OFF: prot_state <= 1'b0;
            `ESCS_OP_CLEAR: cleared_state <= 1'b1;
            `ESCS_OP_AC_OFF: ac_off_state <= 1'b1;
            `ESCS_OP_AC_ON: ac_off_state <= 1'b0;
            default: cleared_state <= cleared_state & ac_off_state;
          endcase
          st_r <= S_IDLE;
        end
        default: st_r <= S_IDLE;
      endcase
    end
  end
endmodule
`default_nettype wire

// ==== escs_host_seq_tb_top.sv ====
`timescale 1ns/1ps
`default_nettype none
`include "escs_consts.vh"
module escs_host_seq_tb_top;
  reg core_clk = 1'b0;
  reg nrst = 1'b0;
  reg cmd_valid = 1'b0;
  reg [2:0] cmd_op = 3'h0;
  reg cmd_prot_on = 1'b0;
  reg cmd_cleared = 1'b0;
  reg pg_valid = 1'b0;
  reg [12:0] pg_addr = 13'h0000;
  reg [7:0] pg_data = 8'h00;
  reg pg_last = 1'b0;
  wire cmd_ready, pg_ready, prot_state, ac_off_state, cleared_state, cmd_err;
  wire [12:0] mem_addr;
  wire [7:0] mem_dq_o;
  wire mem_dq_oe, mem_ce_n, mem_we_n, mem_oe_n, m_prot, m_ac, m_done;
  wire [31:0] m_prog, m_clr;
  reg [31:0] seed = 32'h00012EBB;
  reg [31:0] note_q[$];
  reg [31:0] note;
  reg [6:0] page;
  reg e_prot = 1'b0;
  reg e_ac = 1'b0;
  integer e_prog = 0, e_clr = 0, n_run = 0, n_done = 0, w, k, v;
  integer n_mismatch = 0, samples_checked = 0, n_err = 0;
  escs_host_seq u_dut (.core_clk, .nrst, .cmd_valid, .cmd_op, .cmd_prot_on, .cmd_cleared,
    .cmd_ready, .pg_valid, .pg_addr, .pg_data, .pg_last, .pg_ready, .prot_state,
    .ac_off_state, .cleared_state, .cmd_err, .mem_addr, .mem_dq_o, .mem_dq_oe, .mem_ce_n,
    .mem_we_n, .mem_oe_n);
  escs_mem_model #(.END_NS(3000)) u_mem (.mem_addr, .mem_dq_o, .mem_dq_oe, .mem_ce_n,
    .mem_we_n, .mem_oe_n, .prot(m_prot), .ac_off(m_ac), .blank(), .page_done(m_done),
    .n_prog(m_prog), .n_clr(m_clr));
  always #2.5 core_clk = ~core_clk;
  function [31:0] xs(input [31:0] s);
    reg [31:0] t;
    begin
      t = s ^ (s << 13);
      t = t ^ (t >> 17);
      xs = t ^ (t << 5);
    end
  endfunction
  task chk(input [31:0] got, input [31:0] exp);
    begin
      samples_checked = samples_checked + 1;
      if (got !== exp) begin
        n_mismatch = n_mismatch + 1;
        $display("unexpected at %0t: got %h want %h", $time, got, exp);
      end
    end
  endtask
  task lim;
    begin
      n_mismatch = n_mismatch + 1;
      $display("unexpected at %0t: wait limit reached", $time);
    end
  endtask
  always @(negedge core_clk) begin
    if (cmd_err === 1'b1) n_err = n_err + 1;
  end
  task end_sim;
    begin
      $display("mismatches %0d checks %0d", n_mismatch, samples_checked);
      if (n_mismatch == 0 && samples_checked > 0)
        $display("STATUS OK");
      else
        $display("STATUS NOT OK");
      $finish;
    end
  endtask
  // ==========
  // one command with its page bytes
  task run(input [2:0] op, input integer n);
    begin
      @(negedge core_clk);
      cmd_op = op;
      cmd_prot_on = e_prot;
      cmd_cleared = e_clr > 0;
      cmd_valid = 1'b1;
      for (w = 0; w < 2000 && cmd_ready !== 1'b1; w = w + 1) @(negedge core_clk);
      if (w >= 2000) lim;
      if (op != 3'h3) e_prog = e_prog + n;
      if (op == 3'h3) e_clr = e_clr + 1;
      if (op == 3'h1 || op == 3'h2) e_prot = op == 3'h1;
      if (op == 3'h4 || op == 3'h5) e_ac = op == 3'h4;
      note_q.push_back({e_prot, e_ac, e_clr[5:0], e_prog[23:0]});
      n_run = n_run + 1;
      @(negedge core_clk);
      cmd_valid = 1'b0;
      seed = xs(seed);
      page = seed[6:0];
      for (k = 0; k < n; k = k + 1) begin
        seed = xs(seed);
        pg_addr = {page, k[5:0]};
        pg_data = seed[15:8] | 8'h01;
        pg_last = k == n - 1;
        pg_valid = 1'b1;
        for (w = 0; w < 2000 && pg_ready !== 1'b1; w = w + 1) @(negedge core_clk);
        if (w >= 2000) lim;
        @(negedge core_clk);
      end
      pg_valid = 1'b0;
      for (w = 0; w < 9000 && n_done < n_run; w = w + 1) @(negedge core_clk);
      if (w >= 9000) lim;
    end
  endtask
  always @(posedge m_done) begin
    note = note_q.pop_front();
    @(negedge core_clk);
    for (v = 0; v < 2000 && cmd_ready !== 1'b1; v = v + 1) @(negedge core_clk);
    if (v >= 2000) lim;
    chk({30'h0, prot_state, ac_off_state}, {30'h0, note[31:30]});
    chk({31'h0, cleared_state}, {31'h0, |note[29:24]});
    chk({m_prot, m_ac, m_clr[5:0], m_prog[23:0]}, note);
    n_done = n_done + 1;
  end
  initial begin
    #400000;
    n_mismatch = n_mismatch + 1;
    end_sim;
  end
  initial begin
    repeat (16) @(negedge core_clk);
    nrst = 1'b1;
    repeat (2) @(negedge core_clk);
    run(3'h0, 3);
    run(3'h1, 2);
    run(3'h0, 2);
    run(3'h2, 1);
    run(3'h0, 1);
    run(3'h3, 0);
    run(3'h4, 1);
    run(3'h0, 64);
    run(3'h5, 1);
    chk(n_err, 32'h0);
    end_sim;
  end
endmodule
`default_nettype wire

// ==== escs_mem_model.sv ====
`timescale 1ns/1ps
`default_nettype none
`include "escs_consts.vh"
// ==========
// device recogniser, page ends after a quiet gap
module escs_mem_model #(
  parameter END_NS = 200000
) (
  // memory pins
  input wire [`ESCS_AW-1:0] mem_addr,
  input wire [`ESCS_DW-1:0] mem_dq_o,
  input wire mem_dq_oe,
  input wire mem_ce_n,
  input wire mem_we_n,
  input wire mem_oe_n,
  // device state
  output reg prot = 1'b0,
  output reg ac_off = 1'b0,
  output reg blank = 1'b0,
  output reg page_done = 1'b0,
  output integer n_prog = 0,
  output integer n_clr = 0
);
  integer st = 0;
  integer nd = 0;
  reg open = 1'b0;
  reg ok = 1'b0;
  reg p_on = 1'b0;
  reg p_off = 1'b0;
  realtime last = 0;
  function automatic logic hit(input integer s, input logic [12:0] a, input logic [7:0] d);
    begin
      case (s)
        1, 4: hit = a == `ESCS_ADDR_B && d == `ESCS_DAT_UNLOCK2;
        2: hit = a == `ESCS_ADDR_A && (d == `ESCS_DAT_PROT_ON || d == `ESCS_DAT_EXTEND);
        5: hit = a == `ESCS_ADDR_A && (d == 8'h20 || d == 8'h10 || d == 8'h40 || d == 8'h50);
        default: hit = a == `ESCS_ADDR_A && d == `ESCS_DAT_UNLOCK1;
      endcase
    end
  endfunction
  always @(posedge mem_we_n) begin
    if (!mem_ce_n && mem_oe_n && mem_dq_oe) begin
      last = $realtime;
      if (!open) begin
        open = 1'b1;
        st = 0;
        nd = 0;
        ok = !prot;
      end
      if (st < 6 && hit(st, mem_addr, mem_dq_o)) begin
        st = st + 1;
        if (st == 3 && mem_dq_o == `ESCS_DAT_PROT_ON) begin
          ok = 1'b1;
          p_on = 1'b1;
          st = 9;
        end
        if (st == 6) begin
          ok = 1'b1;
          p_off = mem_dq_o == `ESCS_DAT_PROT_OFF;
          if (mem_dq_o == `ESCS_DAT_AC_OFF) ac_off = 1'b1;
          if (mem_dq_o == `ESCS_DAT_AC_ON) ac_off = 1'b0;
          if (mem_dq_o == `ESCS_DAT_CLEAR) n_clr = n_clr + 1;
          if (mem_dq_o == `ESCS_DAT_CLEAR) blank = 1'b1;
        end
      end else begin
        st = 9;
        nd = nd + 1;
        if (ok) n_prog = n_prog + 1;
        if (ok) blank = 1'b0;
      end
    end
  end
  always #100 begin
    page_done = 1'b0;
    if (open && $realtime - last > END_NS) begin
      open = 1'b0;
      if (nd > 0) prot = (prot | p_on) & !p_off;
      if (nd > 0) p_on = 1'b0;
      p_off = 1'b0;
      page_done = 1'b1;
    end
  end
endmodule
`default_nettype wire

// ==== escs_props.sv ====
`timescale 1ns/1ps
`default_nettype none
`include "escs_consts.vh"
// ==========
// memory write strobe checks
module escs_chk (
  // clock and reset
  input wire core_clk,
  input wire nrst,
  // command
  input wire cmd_valid,
  input wire cmd_ready,
  input wire [2:0] cmd_op,
  input wire cmd_prot_on,
  // status
  input wire prot_state,
  input wire ac_off_state,
  // memory pins
  input wire [`ESCS_AW-1:0] mem_addr,
  input wire [`ESCS_DW-1:0] mem_dq_o,
  input wire mem_dq_oe,
  input wire mem_ce_n,
  input wire mem_we_n,
  input wire mem_oe_n
);
  reg [7:0] lo_r;
  reg [7:0] hi_r;
  // cycles with write strobe low, and since it last rose
  always @(posedge core_clk) begin
    if (!nrst) begin
      lo_r <= 8'h00;
      hi_r <= 8'hFF;
    end else begin
      lo_r <= mem_we_n ? 8'h00 : lo_r + 8'h01;
      hi_r <= !mem_we_n ? 8'h00 : (hi_r == 8'hFF ? hi_r : hi_r + 8'h01);
    end
  end
  default clocking @(posedge core_clk); endclocking
  default disable iff (!nrst);
  rst_idle_a: assert property ($rose(nrst) |-> mem_ce_n && mem_we_n &&
    !mem_dq_oe && !prot_state && !ac_off_state) else $error("not idle after reset");
  oe_high_a: assert property (mem_oe_n) else $error("output enable low");
  we_in_ce_a: assert property (!mem_we_n |-> !mem_ce_n && mem_dq_oe)
    else $error("write strobe outside chip select");
  we_width_a: assert property ($rose(mem_we_n) |-> lo_r >= 8'h1E)
    else $error("write pulse too short");
  dq_stable_a: assert property (!mem_ce_n && !$past(mem_ce_n) |->
    $stable(mem_addr) && $stable(mem_dq_o)) else $error("bus moved in cycle");
  addr_setup_a: assert property ($fell(mem_we_n) |-> !$past(mem_ce_n, 4))
    else $error("address setup short");
  load_gap_a: assert property ($fell(mem_we_n) |-> hi_r >= 8'h28)
    else $error("byte load gap short");
  prefix_a: assert property (cmd_valid && cmd_ready && (cmd_op != 3'h0 || cmd_prot_on)
    |-> ##[1:8] $fell(mem_ce_n) && mem_addr == `ESCS_ADDR_A && mem_dq_o == `ESCS_DAT_UNLOCK1)
    else $error("command prefix missing");
  cover property (cmd_valid && cmd_ready && cmd_op == 3'h3);
  cover property ($rose(prot_state));
  cover property ($rose(ac_off_state));
endmodule
bind escs_host_seq escs_chk u_chk (.core_clk, .nrst, .cmd_valid, .cmd_ready, .cmd_op,
  .cmd_prot_on, .prot_state, .ac_off_state, .mem_addr, .mem_dq_o, .mem_dq_oe, .mem_ce_n,
  .mem_we_n, .mem_oe_n);
`default_nettype wire
